// ===== common/ovc_pkg.sv
// Shared constants and types for the overlay and calibration controller.
// Assumes a 25 MHz system clock and a four-bit address, four-bit data serial word.
package ovc_pkg;

    // ----------------------------------------------------------------
    // Clock and pin timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CAL_LOW_NS = 200;
    localparam int CAL_GAP_NS = 80;
    localparam int DEV_RESET_NS = 400;
    // Least times, rounded up to whole cycles
    localparam int CAL_LOW_CYC = (CAL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_GAP_CYC = (CAL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEV_RESET_CYC = (DEV_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Device register map
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_IN_FIRST = 4'h0;
    localparam logic [3:0] REG_IN_LAST = 4'h3;
    localparam logic [3:0] REG_OUT_FIRST = 4'h8;
    localparam logic [3:0] REG_OUT_LAST = 4'hC;
    localparam logic [3:0] REG_SYNC_OVERLAY_CAL_MODE = 4'hD;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam int MODE_AUTOCAL_POS = 0;
    localparam int MODE_ALTERNATE_POS = 1;
    localparam int MODE_TRANSPARENT_POS = 2;
    localparam int SER_BITS = 8;
    localparam int IN_STAGES = 4;

    // Common-mode level codes for the sync encoder
    localparam logic [1:0] CM_2V0 = 2'h0;
    localparam logic [1:0] CM_2V5 = 2'h1;
    localparam logic [1:0] CM_3V0 = 2'h2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic spare;
        logic transparent_bit;
        logic alternate_bit;
        logic autocal_bit;
    } ovc_mode_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [3:0] data;
    } ovc_xp_req_s;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic sload;
    } ovc_ser_pins_s;

    typedef struct packed {
        logic [1:0] red;
        logic [1:0] green;
        logic [1:0] blue;
    } ovc_cm_s;

endpackage

// ===== verilog/ovc_serial_shift.sv
// Serial word shifter: sends one address and data word MSB first, then loads.
// Assumes the device samples data on the rising serial clock.
module ovc_serial_shift (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic [7:0] i_word,
    output logic o_busy,
    output logic o_done,
    output ovc_pkg::ovc_ser_pins_s o_pins
);

    typedef enum logic [1:0] {SER_IDLE, SER_LOW, SER_HIGH, SER_LOAD} ovc_ser_st_e;

    typedef struct packed {
        ovc_ser_st_e st;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        ovc_pkg::ovc_ser_pins_s pins;
    } ovc_ser_state_s;

    ovc_ser_state_s q;
    ovc_ser_state_s d;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        case (q.st)
            SER_IDLE: begin
                if (i_start) begin
                    d.st = SER_LOW;
                    d.shift = i_word;
                    d.bit_cnt = 3'h0;
                    d.pins.sdata = i_word[7];
                end
            end
            SER_LOW: begin
                d.pins.sclk = 1'b1;
                d.st = SER_HIGH;
            end
            SER_HIGH: begin
                d.pins.sclk = 1'b0;
                if (q.bit_cnt == 3'(ovc_pkg::SER_BITS - 1)) begin
                    d.pins.sload = 1'b1;
                    d.st = SER_LOAD;
                end else begin
                    d.shift = {q.shift[6:0], 1'b0};
                    d.pins.sdata = q.shift[6];
                    d.bit_cnt = q.bit_cnt + 3'h1;
                    d.st = SER_LOW;
                end
            end
            SER_LOAD: begin
                d.pins.sload = 1'b0;
                d.st = SER_IDLE;
            end
            default: d.st = SER_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '{st: SER_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign o_busy = (q.st != SER_IDLE);
    assign o_done = (q.st == SER_LOAD);
    assign o_pins = q.pins;

    // Load strobe follows the last bit at a fixed distance
    a_ser_frame: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_start && q.st == SER_IDLE) |-> ##17 (o_pins.sload && !o_pins.sclk))
        else $error("serial load strobe not at end of word");

endmodule // ovc_serial_shift

// ===== verilog/ovc_host_ctrl.sv
// Controller for a crosspoint's switchable output group: overlay pin, calibrate
// sequencing, mode register and selector writes over the serial port.
// Assumes the device's decoded sync outputs and a line porch marker arrive on i_clk.

// Overview of operation
// - Without supervisor, calibrate overlay state then thru state, one pulse each.
// - Recalibrate after crosspoint path change or transparent/opaque change.
// - Refresh calibration once per line during a black-level porch.
// - With supervisor, overlay only within active video, never around sync.
// - Keep the four input selector values distinct.
// - Broadcast by pointing several output selectors at one input stage.
// - Transmitter encodes each sync pair as distinct common-mode levels.
module ovc_host_ctrl (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_mode_write,
    input ovc_pkg::ovc_mode_s i_mode,
    input wire logic i_xp_write,
    input ovc_pkg::ovc_xp_req_s i_xp_req,
    input wire logic i_overlay_req,
    input wire logic i_active_video,
    input wire logic i_hsync,
    input wire logic i_vsync,
    input wire logic i_line_porch,
    input wire logic i_tx_hsync,
    input wire logic i_tx_vsync,
    output logic o_busy,
    output logic o_ack,
    output logic o_refused,
    output logic o_dev_reset_n,
    output logic o_overlay_n,
    output logic o_transparent_n,
    output logic o_cal_n,
    output logic o_next_is_overlay,
    output logic o_cal_stale,
    output ovc_pkg::ovc_ser_pins_s o_ser,
    output ovc_pkg::ovc_cm_s o_tx_cm
);

    typedef enum logic [2:0] {
        ST_DEV_RESET, ST_SER, ST_IDLE, ST_CAL_LOW, ST_CAL_GAP
    } ovc_st_e;

    typedef struct packed {
        ovc_st_e st;
        ovc_pkg::ovc_mode_s mode;
        logic [3:0][3:0] in_sel;
        logic [3:0] in_valid;
        logic [3:0] cnt;
        logic step;
        logic next_ovl;
        logic stale;
        logic ovl_n;
        logic cal_n;
        logic dev_rst_n;
        logic ack;
        logic refused;
        logic ser_start;
        logic [7:0] ser_word;
        ovc_pkg::ovc_cm_s cm;
    } ovc_state_s;

    ovc_state_s q;
    ovc_state_s d;
    logic ser_done;
    logic [3:0] dup_hit;
    logic dup;
    logic in_addr;
    logic sync_clear;

    // ----------------------------------------------------------------
    // Selector checks
    // ----------------------------------------------------------------
    // A new input selection must not repeat another stage's value
    genvar gi;
    generate
        for (gi = 0; gi < ovc_pkg::IN_STAGES; gi++) begin : g_dup
            assign dup_hit[gi] = q.in_valid[gi] && (q.in_sel[gi] == i_xp_req.data)
                && (i_xp_req.addr[1:0] != 2'(gi));
        end
    endgenerate

    assign in_addr = (i_xp_req.addr <= ovc_pkg::REG_IN_LAST);
    assign dup = in_addr && (|dup_hit);
    assign sync_clear = i_active_video && !i_hsync && !i_vsync;

    // Common-mode level set for one sync pair
    function automatic ovc_pkg::ovc_cm_s encode_sync(input logic h, input logic v);
        ovc_pkg::ovc_cm_s c;
        case ({h, v})
            2'b01: c = '{red: ovc_pkg::CM_3V0, green: ovc_pkg::CM_2V0, blue: ovc_pkg::CM_2V5};
            2'b00: c = '{red: ovc_pkg::CM_2V5, green: ovc_pkg::CM_3V0, blue: ovc_pkg::CM_2V0};
            2'b10: c = '{red: ovc_pkg::CM_2V0, green: ovc_pkg::CM_3V0, blue: ovc_pkg::CM_2V5};
            default: c = '{red: ovc_pkg::CM_2V5, green: ovc_pkg::CM_2V0, blue: ovc_pkg::CM_3V0};
        endcase
        return c;
    endfunction

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.refused = 1'b0;
        d.ser_start = 1'b0;
        d.cm = encode_sync(i_tx_hsync, i_tx_vsync);
        case (q.st)
            ST_DEV_RESET: begin
                if (q.cnt == 4'h0) begin
                    d.dev_rst_n = 1'b1;
                    d.next_ovl = 1'b1;
                    d.ser_word = {ovc_pkg::REG_SYNC_OVERLAY_CAL_MODE, q.mode};
                    d.ser_start = 1'b1;
                    d.st = ST_SER;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            ST_SER: begin
                // Keep following the overlay request while the word goes out
                d.ovl_n = !(i_overlay_req && sync_clear && !q.stale);
                if (ser_done) begin
                    d.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // Overlay only in clean active video with a fresh calibration
                d.ovl_n = !(i_overlay_req && sync_clear && !q.stale);
                if (i_mode_write) begin
                    d.mode = i_mode;
                    if (i_mode.transparent_bit != q.mode.transparent_bit) begin
                        d.stale = 1'b1;
                    end
                    d.ser_word = {ovc_pkg::REG_SYNC_OVERLAY_CAL_MODE, i_mode};
                    d.ser_start = 1'b1;
                    d.ack = 1'b1;
                    d.st = ST_SER;
                end else if (i_xp_write) begin
                    if (dup || i_xp_req.addr >= ovc_pkg::REG_SYNC_OVERLAY_CAL_MODE) begin
                        d.refused = 1'b1;
                    end else begin
                        if (in_addr) begin
                            d.in_sel[i_xp_req.addr[1:0]] = i_xp_req.data;
                            d.in_valid[i_xp_req.addr[1:0]] = 1'b1;
                        end
                        // Output selectors may share a stage for broadcast
                        d.stale = 1'b1;
                        d.ser_word = i_xp_req;
                        d.ser_start = 1'b1;
                        d.ack = 1'b1;
                        d.st = ST_SER;
                    end
                end else if (i_line_porch && q.mode.autocal_bit) begin
                    // Separate mode starts on the overlay state
                    d.ovl_n = q.mode.alternate_bit;
                    d.step = 1'b0;
                    d.cal_n = 1'b0;
                    d.cnt = 4'(ovc_pkg::CAL_LOW_CYC - 1);
                    d.st = ST_CAL_LOW;
                end
            end
            ST_CAL_LOW: begin
                if (q.cnt == 4'h0) begin
                    d.cal_n = 1'b1;
                    if (q.mode.alternate_bit) begin
                        d.next_ovl = !q.next_ovl;
                    end
                    d.cnt = 4'(ovc_pkg::CAL_GAP_CYC - 1);
                    d.st = ST_CAL_GAP;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            ST_CAL_GAP: begin
                if (q.cnt != 4'h0) begin
                    d.cnt = q.cnt - 4'h1;
                end else if (!q.mode.alternate_bit && !q.step) begin
                    // Second pulse calibrates the thru state
                    d.step = 1'b1;
                    d.ovl_n = 1'b1;
                    d.cal_n = 1'b0;
                    d.cnt = 4'(ovc_pkg::CAL_LOW_CYC - 1);
                    d.st = ST_CAL_LOW;
                end else begin
                    d.ovl_n = 1'b1;
                    d.stale = 1'b0;
                    d.st = ST_IDLE;
                end
            end
            default: d.st = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '{st: ST_DEV_RESET, cnt: 4'(ovc_pkg::DEV_RESET_CYC - 1), ovl_n: 1'b1,
                   cal_n: 1'b1, next_ovl: 1'b1, mode: ovc_pkg::MODE_RESET, default: '0};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Serial port and outputs
    // ----------------------------------------------------------------
    ovc_serial_shift u_ser (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_start(q.ser_start),
        .i_word(q.ser_word),
        .o_busy(),
        .o_done(ser_done),
        .o_pins(o_ser)
    );

    assign o_busy = (q.st != ST_IDLE);
    assign o_ack = q.ack;
    assign o_refused = q.refused;
    assign o_dev_reset_n = q.dev_rst_n;
    assign o_overlay_n = q.ovl_n;
    assign o_transparent_n = !q.mode.transparent_bit;
    assign o_cal_n = q.cal_n;
    assign o_next_is_overlay = q.next_ovl;
    assign o_cal_stale = q.stale;
    assign o_tx_cm = q.cm;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_ovl_pulse;
        $fell(o_cal_n) && !o_overlay_n && !q.mode.alternate_bit;
    endsequence
    sequence s_thru_pulse;
        !o_cal_n && o_overlay_n && $past(o_cal_n);
    endsequence

    a_dev_reset_release: assert property (
        (q.st == ST_DEV_RESET && q.cnt == 4'h0) |=> (o_dev_reset_n && o_next_is_overlay))
        else $error("device reset release wrong");
    a_cal_pulse_width: assert property (
        $fell(o_cal_n) |-> (!o_cal_n)[*5] ##1 o_cal_n)
        else $error("calibrate pulse width wrong");
    a_porch_starts_cal: assert property (
        (q.st == ST_IDLE && i_line_porch && !i_mode_write && !i_xp_write
            && q.mode.autocal_bit) |=> !o_cal_n)
        else $error("porch did not start calibration");
    a_separate_steps: assert property (
        s_ovl_pulse |-> ##7 s_thru_pulse)
        else $error("thru pulse did not follow overlay pulse");
    a_overlay_window: assert property (
        (!o_overlay_n && q.st inside {ST_IDLE, ST_SER} && $past(q.st inside {ST_IDLE, ST_SER}))
            |-> $past(sync_clear && i_overlay_req && !q.stale))
        else $error("overlay outside active video");
    a_alt_ovl_off: assert property (
        (!o_cal_n && q.mode.alternate_bit) |-> o_overlay_n)
        else $error("overlay selected during supervised calibration");
    a_toggle_advance: assert property (
        ($rose(o_cal_n) && q.mode.alternate_bit) |-> (o_next_is_overlay != $past(o_next_is_overlay)))
        else $error("alternation not advanced");
    a_path_stale: assert property (
        (q.st == ST_IDLE && !i_mode_write && i_xp_write) |=> (o_cal_stale || o_refused))
        else $error("path change not marked for recalibration");
    a_dup_refused: assert property (
        (q.st == ST_IDLE && !i_mode_write && i_xp_write && dup) |=> (o_refused && !o_ack))
        else $error("duplicate input selection accepted");
    a_sync_encode: assert property (
        (i_tx_hsync && i_tx_vsync) |=> (o_tx_cm.blue == ovc_pkg::CM_3V0))
        else $error("sync encoding wrong");

endmodule // ovc_host_ctrl

// ===== verification/ovc_dev_model.sv
// Behavioural model of the crosspoint switchable group and its register port.
// Assumes the controller's serial, overlay, calibrate and reset pins at its ports.
module ovc_dev_model (
    input ovc_pkg::ovc_ser_pins_s i_ser,
    input wire logic i_dev_reset_n,
    input wire logic i_overlay_n,
    input wire logic i_transparent_n,
    input wire logic i_cal_n,
    input ovc_pkg::ovc_cm_s i_tx_cm,
    output logic o_hsync,
    output logic o_vsync,
    output logic o_route_ovl,
    output logic o_avg,
    output logic o_at_ref,
    output logic o_next_ovl,
    output logic [7:0] o_cal_ovl,
    output logic [7:0] o_cal_thru,
    output logic [15:0][3:0] o_regs
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    logic [7:0] shift_q;
    ovc_pkg::ovc_mode_s mode;
    wire sclk = i_ser.sclk;
    wire sload = i_ser.sload;
    assign mode = o_regs[13];
    // Shift in, first bit ends up on top
    always @(posedge sclk) shift_q <= {shift_q[6:0], i_ser.sdata};
    // Load the addressed register; reset clears all
    always @(posedge sload or negedge i_dev_reset_n) begin
        if (!i_dev_reset_n) o_regs <= '0;
        else o_regs[shift_q[7:4]] <= shift_q[3:0];
    end
    // ----------------------------------------------------------------
    // Switchable group
    // ----------------------------------------------------------------
    // Routing, averaging and sample-phase forcing
    assign o_route_ovl = !i_overlay_n;
    assign o_avg = o_route_ovl && (!i_transparent_n || mode.transparent_bit);
    assign o_at_ref = !i_cal_n && mode.autocal_bit;
    // Correction counters per path, updated at each release
    always @(posedge i_cal_n or negedge i_dev_reset_n) begin
        if (!i_dev_reset_n) begin
            o_next_ovl <= 1'b1;
            o_cal_ovl <= 8'h00;
            o_cal_thru <= 8'h00;
        end else if (mode.autocal_bit) begin
            if (!i_overlay_n || (mode.alternate_bit && o_next_ovl)) begin
                o_cal_ovl <= o_cal_ovl + 8'h01;
            end else begin
                o_cal_thru <= o_cal_thru + 8'h01;
            end
            if (mode.alternate_bit && i_overlay_n) o_next_ovl <= !o_next_ovl;
        end
    end
    // ----------------------------------------------------------------
    // Sync comparators, levels in tenths of a volt
    // ----------------------------------------------------------------
    function automatic logic [6:0] lvl(input logic [1:0] c);
        return 7'h14 + 7'h05 * {5'h00, c};
    endfunction
    // Both decoded from the same instant, so no skew
    assign o_hsync = lvl(i_tx_cm.blue) * 7'h02 > lvl(i_tx_cm.red) + lvl(i_tx_cm.green);
    assign o_vsync = lvl(i_tx_cm.red) + lvl(i_tx_cm.blue) > lvl(i_tx_cm.green) * 7'h02;
endmodule // ovc_dev_model

// ===== verification/testbench.sv
// Self-checking bench for the overlay and calibration controller.
// Assumes ovc_host_ctrl and the device model ovc_dev_model.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_reset_n, i_mode_write, i_xp_write, i_overlay_req, i_active_video;
    logic i_line_porch, i_tx_hsync, i_tx_vsync, m_hs, m_vs, m_route, m_next;
    logic o_busy, o_ack, o_refused, o_dev_reset_n, o_overlay_n, o_transparent_n;
    logic o_cal_n, o_next_is_overlay, o_cal_stale;
    ovc_pkg::ovc_mode_s i_mode;
    ovc_pkg::ovc_xp_req_s i_xp_req;
    ovc_pkg::ovc_ser_pins_s o_ser;
    ovc_pkg::ovc_cm_s o_tx_cm;
    logic [7:0] m_ovl, m_thru, ovl0, thru0;
    logic [15:0][3:0] m_regs;
    logic [31:0] rnd;
    logic [3:0] d;
    ovc_pkg::ovc_cm_s cm_exp;
    bit exp_q[$];
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 32'h6a3f3da8;

    // Clock, 40 ns period
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    ovc_host_ctrl i_ovc_host_ctrl (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_mode_write(i_mode_write), .i_mode(i_mode), .i_xp_write(i_xp_write),
        .i_xp_req(i_xp_req), .i_overlay_req(i_overlay_req), .i_active_video(i_active_video),
        .i_hsync(m_hs), .i_vsync(m_vs), .i_line_porch(i_line_porch),
        .i_tx_hsync(i_tx_hsync), .i_tx_vsync(i_tx_vsync), .o_busy(o_busy), .o_ack(o_ack),
        .o_refused(o_refused), .o_dev_reset_n(o_dev_reset_n), .o_overlay_n(o_overlay_n),
        .o_transparent_n(o_transparent_n), .o_cal_n(o_cal_n),
        .o_next_is_overlay(o_next_is_overlay), .o_cal_stale(o_cal_stale), .o_ser(o_ser),
        .o_tx_cm(o_tx_cm));

    ovc_dev_model i_ovc_dev_model (.i_ser(o_ser), .i_dev_reset_n(o_dev_reset_n),
        .i_overlay_n(o_overlay_n), .i_transparent_n(o_transparent_n), .i_cal_n(o_cal_n),
        .i_tx_cm(o_tx_cm), .o_hsync(m_hs), .o_vsync(m_vs), .o_route_ovl(m_route),
        .o_avg(), .o_at_ref(), .o_next_ovl(m_next), .o_cal_ovl(m_ovl),
        .o_cal_thru(m_thru), .o_regs(m_regs));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic idle_wait();
        int n;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_busy !== 1'b0 && n < 200);
        if (n >= 200) check("idle_wait", 0, 1);
    endtask

    // One register write; poke repeats the strobe while busy
    task automatic wr(input bit md, input logic [3:0] a, input logic [3:0] v, input bit ok,
                      input bit poke);
        idle_wait();
        @(posedge i_clk);
        i_mode_write <= md;
        i_xp_write <= !md;
        i_mode <= v;
        i_xp_req <= {a, v};
        exp_q.push_back(ok);
        @(posedge i_clk);
        i_mode_write <= 1'b0;
        i_xp_write <= poke;
        @(posedge i_clk);
        i_xp_write <= 1'b0;
        idle_wait();
    endtask

    // Porch marker, then count calibrate-low cycles
    task automatic porch(input int exp_lows);
        int lows;
        lows = 0;
        idle_wait();
        @(posedge i_clk);
        i_line_porch <= 1'b1;
        @(posedge i_clk);
        i_line_porch <= 1'b0;
        repeat (20) begin
            @(negedge i_clk);
            if (o_cal_n === 1'b0) lows++;
        end
        check("cal_low_cycles", lows, exp_lows);
    endtask

    // Compare each write answer with the oldest note
    always @(negedge i_clk) begin
        if (i_reset_n === 1'b1 && (o_ack === 1'b1 || o_refused === 1'b1)) begin
            if (exp_q.size() == 0) check("unexpected_answer", 1, 0);
            else check("write_ack", o_ack, exp_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {i_reset_n, i_mode_write, i_xp_write, i_overlay_req, i_active_video} = 5'h00;
        {i_line_porch, i_tx_hsync, i_tx_vsync} = 3'h0;
        i_mode = '0;
        i_xp_req = '0;
        repeat (4) @(posedge i_clk);
        check("dev_reset_low", o_dev_reset_n, 0);
        i_reset_n <= 1'b1;
        idle_wait();
        check("mode_after_reset", m_regs[13], 0);
        check("dev_reset_high", o_dev_reset_n, 1);
        check("next_is_overlay", o_next_is_overlay, 1);
        $display("test reset done");
        wr(1'b1, 4'hD, 4'h5, 1'b1, 1'b0);
        check("mode_reg", m_regs[13], 4'h5);
        check("transparent_pin", o_transparent_n, 0);
        $display("test mode done");
        rnd = $random(seed);
        d = 4'h4 + {1'b0, rnd[2:0]};
        wr(1'b0, 4'h0, 4'h3, 1'b1, 1'b1);
        wr(1'b0, 4'h1, 4'h3, 1'b0, 1'b0);
        wr(1'b0, 4'h1, d, 1'b1, 1'b0);
        wr(1'b0, 4'hE, 4'h1, 1'b0, 1'b0);
        wr(1'b0, 4'h8, 4'h0, 1'b1, 1'b0);
        wr(1'b0, 4'hC, 4'h0, 1'b1, 1'b0);
        check("sel_a", m_regs[0], 4'h3);
        check("sel_b", m_regs[1], d);
        check("unmapped", m_regs[14], 4'h0);
        check("out_s", m_regs[12], 4'h0);
        check("stale_set", o_cal_stale, 1);
        $display("test selectors done");
        ovl0 = m_ovl;
        thru0 = m_thru;
        porch(10);
        check("cal_ovl", m_ovl, ovl0 + 8'h01);
        check("cal_thru", m_thru, thru0 + 8'h01);
        check("stale_clear", o_cal_stale, 0);
        $display("test separate done");
        wr(1'b1, 4'hD, 4'h3, 1'b1, 1'b0);
        porch(5);
        check("alt_ovl", m_ovl, ovl0 + 8'h02);
        check("next_ctrl", o_next_is_overlay, 0);
        check("next_dev", m_next, 0);
        porch(5);
        check("alt_thru", m_thru, thru0 + 8'h02);
        check("next_ctrl2", o_next_is_overlay, 1);
        $display("test alternate done");
        @(posedge i_clk);
        i_overlay_req <= 1'b1;
        i_active_video <= 1'b1;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        check("overlay_on", o_overlay_n, 0);
        check("route_ovl", m_route, 1);
        @(posedge i_clk);
        // Both syncs, so each decoder sees a clear level
        i_tx_hsync <= 1'b1;
        i_tx_vsync <= 1'b1;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        check("overlay_sync", o_overlay_n, 1);
        @(posedge i_clk);
        i_overlay_req <= 1'b0;
        i_active_video <= 1'b0;
        $display("test overlay done");
        repeat (8) begin
            rnd = $random(seed);
            @(posedge i_clk);
            i_tx_hsync <= rnd[0];
            i_tx_vsync <= rnd[1];
            repeat (2) @(posedge i_clk);
            @(negedge i_clk);
            // H alone leaves blue level with the red-green average: no sync seen
            check("hsync", m_hs, rnd[0] & rnd[1]);
            case ({rnd[0], rnd[1]})
                2'b01: cm_exp = '{ovc_pkg::CM_3V0, ovc_pkg::CM_2V0, ovc_pkg::CM_2V5};
                2'b00: cm_exp = '{ovc_pkg::CM_2V5, ovc_pkg::CM_3V0, ovc_pkg::CM_2V0};
                2'b10: cm_exp = '{ovc_pkg::CM_2V0, ovc_pkg::CM_3V0, ovc_pkg::CM_2V5};
                default: cm_exp = '{ovc_pkg::CM_2V5, ovc_pkg::CM_2V0, ovc_pkg::CM_3V0};
            endcase
            check("tx_cm", o_tx_cm, cm_exp);
            check("vsync", m_vs, rnd[1]);
        end
        $display("test sync done");
        wr(1'b1, 4'hD, 4'h0, 1'b1, 1'b0);
        porch(0);
        $display("test autocal off done");
        check("answers_left", exp_q.size(), 0);
        finish_test();
    end
endmodule // testbench
